// ===== shared/nvc_pkg.sv
package nvc_pkg;
    // Register offsets in the I/O space.
    localparam logic [7:0] CtrlOffset  = 8'h1f;
    localparam logic [7:0] DataOffset  = 8'h20;
    localparam logic [7:0] AddrLOffset = 8'h21;
    localparam logic [7:0] AddrHOffset = 8'h22;
    // Control field positions.
    localparam int ReadStrobeBit  = 0;
    localparam int ProgStrobeBit  = 1;
    localparam int MasterEnBit    = 2;
    localparam int ReadyIrqEnBit  = 3;
    localparam int ModeLsb        = 4;
    localparam int ModeMsb        = 5;
    // Widths and sizes.
    localparam int AddrWidth      = 12;
    localparam int AddrHighBits   = 4;
    localparam int MemDepth       = 4096;
    localparam int PageBytes      = 8;
    localparam int PageIdxWidth   = 3;
    // Master enable window.
    localparam logic [2:0] ArmCycles = 3'h4;
    // Programming times.
    localparam int ClockMhz       = 200;
    localparam int WriteTimeUs    = 4500;
    localparam int EraseTimeUs    = 8500;
    localparam int WriteCycles    = WriteTimeUs * ClockMhz;
    localparam int EraseCycles    = EraseTimeUs * ClockMhz;
    localparam int LoadCycles     = 1;
    localparam int TimerWidth     = 24;
    localparam logic [7:0] ErasedByte = 8'hff;

    typedef enum logic [1:0] {
        ModeAtomic,
        ModeErase,
        ModeWrite,
        ModeLoad
    } nvc_mode_type;
endpackage

// ===== src/nvc_controller.sv
`timescale 1ns/1ps
`default_nettype none
module nvc_controller
    import nvc_pkg::*;
#(
    parameter int WriteTime = nvc_pkg::WriteCycles,
    parameter int EraseTime = nvc_pkg::EraseCycles
) (
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic [7:0] ioAddr,
    input  wire logic [7:0] ioWdata,
    input  wire logic       ioWrite,
    input  wire logic       ioRead,
    input  wire logic       globalIrqFlag,
    output logic      [7:0] ioRdata,
    output logic            readyIrq,
    output logic            busy
);
    import nvc_pkg::*;

    // ************************************************************
    // Reset synchroniser
    // ************************************************************
    logic rstMeta;
    logic rstSync;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end
    // A reset seen by the clocked logic; it clears master and ready enables, clears the mode only when idle, and leaves programming running.
    logic sysReset;
    assign sysReset = !rstSync;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    typedef enum logic [1:0] {StIdle, StLoad, StProg} nvc_state_type;

    nvc_state_type           state_reg, state_next;
    logic [1:0]              mode_reg, mode_next;
    logic                    irqEn_reg, irqEn_next;
    logic                    master_reg, master_next;
    logic [2:0]              armCnt_reg, armCnt_next;
    logic [AddrWidth-1:0]    addr_reg, addr_next;
    logic [7:0]              data_reg, data_next;
    logic [TimerWidth-1:0]   timer_reg, timer_next;
    logic [1:0]              opMode_reg, opMode_next;
    logic [7:0]              mem_reg [MemDepth];
    logic [7:0]              buf_reg [PageBytes];
    logic [PageBytes-1:0]    bufValid_reg, bufValid_next;
    logic [7:0]              bufByte_next;
    logic                    bufLoad;
    logic                    commit;

    logic ctrlWr, strobeReq;
    assign ctrlWr    = ioWrite && hit(ioAddr, CtrlOffset);
    assign strobeReq = ctrlWr && ioWdata[ProgStrobeBit];
    assign busy      = (state_reg != StIdle);

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        state_next   = state_reg;
        mode_next    = mode_reg;
        irqEn_next   = irqEn_reg;
        master_next  = master_reg;
        armCnt_next  = armCnt_reg;
        addr_next    = addr_reg;
        data_next    = data_reg;
        timer_next   = timer_reg;
        opMode_next  = opMode_reg;
        bufValid_next = bufValid_reg;
        bufByte_next = data_reg;
        bufLoad      = 1'b0;
        commit       = 1'b0;
        // Master enable times out after four cycles.
        if (master_reg) begin
            if (armCnt_reg == ArmCycles - 3'h1) begin
                master_next = 1'b0;
            end
            armCnt_next = armCnt_reg + 3'h1;
        end
        if (ioWrite && !busy) begin
            // Address and data stay frozen while an operation runs.
            if (hit(ioAddr, AddrLOffset)) begin
                addr_next[7:0] = ioWdata;
            end
            if (hit(ioAddr, AddrHOffset)) begin
                addr_next[AddrWidth-1:8] = ioWdata[AddrHighBits-1:0];
            end
            if (hit(ioAddr, DataOffset)) begin
                data_next = ioWdata;
            end
        end
        if (ctrlWr) begin
            irqEn_next = ioWdata[ReadyIrqEnBit];
            if (!busy) begin
                mode_next = ioWdata[ModeMsb:ModeLsb];
            end
            if (ioWdata[MasterEnBit] && !master_reg) begin
                master_next = 1'b1;
                armCnt_next = 3'h0;
            end
            if (ioWdata[ReadStrobeBit] && !busy) begin
                data_next = mem_reg[addr_reg];
            end
        end
        case (state_reg)
            StIdle: begin
                // Strobe counts only inside the armed window.
                if (strobeReq && master_reg) begin
                    opMode_next = mode_reg;
                    master_next = 1'b0;
                    if (mode_reg == 2'(ModeLoad)) begin
                        state_next = StLoad;
                        timer_next = TimerWidth'(LoadCycles);
                        bufLoad    = 1'b1;
                    end else begin
                        state_next = StProg;
                        // The final byte joins the page in the same command.
                        bufLoad    = 1'b1;
                        timer_next = (mode_reg == 2'(ModeErase)) ?
                            TimerWidth'(EraseTime) :
                            (mode_reg == 2'(ModeWrite)) ?
                            TimerWidth'(WriteTime) :
                            TimerWidth'(EraseTime + WriteTime);
                    end
                end
            end
            StLoad, StProg: begin
                if (timer_reg <= TimerWidth'(1)) begin
                    state_next = StIdle;
                    timer_next = '0;
                    if (state_reg == StProg) begin
                        commit        = 1'b1;
                        bufValid_next = '0;
                    end
                end else begin
                    timer_next = timer_reg - TimerWidth'(1);
                end
            end
            default: state_next = StIdle;
        endcase
        if (bufLoad) begin
            bufValid_next[addr_reg[PageIdxWidth-1:0]] = 1'b1;
        end
        if (sysReset) begin
            master_next = 1'b0;
            irqEn_next  = 1'b0;
            // A running operation survives reset.
            if (!busy) begin
                mode_next     = 2'(ModeAtomic);
                bufValid_next = '0;
            end
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge mclk) begin
        state_reg    <= state_next;
        mode_reg     <= mode_next;
        irqEn_reg    <= irqEn_next;
        master_reg   <= master_next;
        armCnt_reg   <= armCnt_next;
        timer_reg    <= timer_next;
        opMode_reg   <= opMode_next;
        bufValid_reg <= bufValid_next;
    end

    // Address, data and array carry no reset; their content is undefined.
    always_ff @(posedge mclk) begin
        addr_reg <= addr_next;
        data_reg <= data_next;
    end

    // Page buffer and array update.
    genvar gi;
    generate
        for (gi = 0; gi < PageBytes; gi++) begin : gPage
            always_ff @(posedge mclk) begin
                if (bufLoad &&
                    addr_reg[PageIdxWidth-1:0] == PageIdxWidth'(gi)) begin
                    buf_reg[gi] <= bufByte_next;
                end
            end
        end
    endgenerate

    function automatic logic [AddrWidth-1:0] pageCell(
        input logic [AddrWidth-1:0] a,
        input int                   i
    );
        pageCell = {a[AddrWidth-1:PageIdxWidth], PageIdxWidth'(i)};
    endfunction

    // One process owns the array; eight writers would clash on it.
    always_ff @(posedge mclk) begin
        for (int i = 0; i < PageBytes; i++) begin
            if (commit && bufValid_reg[i]) begin
                case (opMode_reg)
                    2'(ModeErase): mem_reg[pageCell(addr_reg, i)] <=
                        ErasedByte;
                    2'(ModeWrite): mem_reg[pageCell(addr_reg, i)] <=
                        mem_reg[pageCell(addr_reg, i)] & buf_reg[i];
                    default: mem_reg[pageCell(addr_reg, i)] <= buf_reg[i];
                endcase
            end
        end
    end

    // ************************************************************
    // Read back
    // ************************************************************
    always_comb begin
        ioRdata = 8'h00;
        if (ioRead) begin
            if (hit(ioAddr, CtrlOffset)) begin
                ioRdata = {2'b00, mode_reg, irqEn_reg, master_reg,
                           busy, 1'b0};
            end else if (hit(ioAddr, AddrHOffset)) begin
                ioRdata = {4'h0, addr_reg[AddrWidth-1:8]};
            end else if (hit(ioAddr, AddrLOffset)) begin
                ioRdata = addr_reg[7:0];
            end else if (hit(ioAddr, DataOffset)) begin
                ioRdata = data_reg;
            end
        end
    end

    assign readyIrq = irqEn_reg && globalIrqFlag && !busy;

    // ************************************************************
    // Checks
    // ************************************************************
    a_master_timeout: assert property (@(posedge mclk) disable iff (!rstSync)
        $rose(master_reg) && !strobeReq |-> ##4 !master_reg)
        else $error("Master enable did not time out.");
    a_no_arm_start: assert property (@(posedge mclk) disable iff (!rstSync)
        !busy && strobeReq && !master_reg |=> !busy)
        else $error("Operation started without master enable.");
    a_arm_start: assert property (@(posedge mclk) disable iff (!rstSync)
        !busy && strobeReq && master_reg |=> busy)
        else $error("Armed strobe did not start.");
    a_mode_hold: assert property (@(posedge mclk) disable iff (!rstSync)
        busy |=> mode_reg == $past(mode_reg))
        else $error("Mode changed while busy.");
    a_addr_hold: assert property (@(posedge mclk) disable iff (!rstSync)
        busy |=> addr_reg == $past(addr_reg))
        else $error("Address changed while busy.");
    a_irq_level: assert property (@(posedge mclk)
        readyIrq == (irqEn_reg && globalIrqFlag && !busy))
        else $error("Ready request mismatch.");
    a_load_short: assert property (@(posedge mclk) disable iff (!rstSync)
        state_reg == StLoad |=> state_reg == StIdle)
        else $error("Buffer load did not finish.");
    a_buf_clear: assert property (@(posedge mclk) disable iff (!rstSync)
        commit |=> bufValid_reg == '0)
        else $error("Page buffer not cleared.");
    c_load: cover property (@(posedge mclk) state_reg == StLoad);
    c_prog: cover property (@(posedge mclk) commit);
    c_reset_busy: cover property (@(posedge mclk) sysReset && busy);
    c_page_write: cover property (@(posedge mclk)
        commit && opMode_reg == 2'(ModeWrite));
    c_irq_seen: cover property (@(posedge mclk) readyIrq);
    a_irq_blocked: assert property (@(posedge mclk) disable iff (!rstSync)
        busy |-> !readyIrq)
        else $error("Ready request raised while busy.");
    a_irq_gate: assert property (@(posedge mclk) disable iff (!rstSync)
        !globalIrqFlag |-> !readyIrq)
        else $error("Ready request without global flag.");
    a_ctrl_reserved: assert property (@(posedge mclk) disable iff (!rstSync)
        ioRead && ioAddr == CtrlOffset |-> ioRdata[7:6] == 2'b00)
        else $error("Reserved control bits not zero.");
    a_addrh_reserved: assert property (@(posedge mclk) disable iff (!rstSync)
        ioRead && ioAddr == AddrHOffset |-> ioRdata[7:4] == 4'h0)
        else $error("Reserved address bits not zero.");
    a_busy_bit: assert property (@(posedge mclk) disable iff (!rstSync)
        ioRead && ioAddr == CtrlOffset |-> ioRdata[ProgStrobeBit] == busy)
        else $error("Strobe bit does not show busy.");
    a_data_hold: assert property (@(posedge mclk) disable iff (!rstSync)
        busy |=> data_reg == $past(data_reg))
        else $error("Data changed while busy.");
    a_start_clear: assert property (@(posedge mclk) disable iff (!rstSync)
        !busy && strobeReq && master_reg |=> !master_reg)
        else $error("Master enable kept after start.");
    a_start_mode: assert property (@(posedge mclk) disable iff (!rstSync)
        !busy && strobeReq && master_reg |=> opMode_reg == $past(mode_reg))
        else $error("Operation mode not latched.");
    a_load_state: assert property (@(posedge mclk) disable iff (!rstSync)
        !busy && strobeReq && master_reg && mode_reg == 2'(ModeLoad)
        |=> state_reg == StLoad)
        else $error("Load mode did not load.");
    a_prog_state: assert property (@(posedge mclk) disable iff (!rstSync)
        !busy && strobeReq && master_reg && mode_reg != 2'(ModeLoad)
        |=> state_reg == StProg)
        else $error("Programming mode did not program.");
    a_arm_window: assert property (@(posedge mclk) disable iff (!rstSync)
        master_reg |-> armCnt_reg < ArmCycles)
        else $error("Master enable outlived its window.");
    a_commit_prog: assert property (@(posedge mclk) disable iff (!rstSync)
        commit |-> state_reg == StProg)
        else $error("Commit outside programming.");
    a_load_nocommit: assert property (@(posedge mclk) disable iff (!rstSync)
        state_reg == StLoad |-> !commit)
        else $error("Buffer load touched the array.");
    a_timer_run: assert property (@(posedge mclk) disable iff (!rstSync)
        state_reg == StProg && timer_reg > TimerWidth'(1)
        |=> state_reg == StProg)
        else $error("Programming ended before its time.");
    // Reset-time checks must run while the synchronised reset is active.
    a_mode_reset: assert property (@(posedge mclk)
        sysReset && !busy |=> mode_reg == 2'(ModeAtomic))
        else $error("Mode not cleared by reset.");
    a_reset_runs: assert property (@(posedge mclk)
        sysReset && busy && timer_reg > TimerWidth'(1) |=> busy)
        else $error("Reset aborted programming.");
endmodule // nvc_controller
`default_nettype wire

// ===== test/eeprom_access_controller_bench.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_access_controller_bench;
    import nvc_pkg::*;
    // ****************************************
    // Short timers keep the run brief.
    // ****************************************
    localparam int Wt = 10;
    localparam int Et = 20;
    logic       mclk          = 1'b0;
    logic       resetn        = 1'b0;
    logic [7:0] ioAddr        = 8'h00;
    logic [7:0] ioWdata       = 8'h00;
    logic       ioWrite       = 1'b0;
    logic       ioRead        = 1'b0;
    logic       globalIrqFlag = 1'b0;
    logic [7:0] ioRdata;
    logic       readyIrq;
    logic       busy;
    logic [7:0] rv;
    int         n_fail        = 0;
    int         comparisons   = 0;
    int         cycleCount    = 0;

    nvc_controller #(.WriteTime(Wt), .EraseTime(Et)) DUT (
        .mclk          (mclk),
        .resetn        (resetn),
        .ioAddr        (ioAddr),
        .ioWdata       (ioWdata),
        .ioWrite       (ioWrite),
        .ioRead        (ioRead),
        .globalIrqFlag (globalIrqFlag),
        .ioRdata       (ioRdata),
        .readyIrq      (readyIrq),
        .busy          (busy)
    );

    always #2.5 mclk = ~mclk;

    // ****************************************
    // Shared tasks.
    // ****************************************
    task automatic stop_test;
        if (n_fail == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // A hang would otherwise hide every later mismatch.
    always @(posedge mclk) begin
        cycleCount++;
        if (cycleCount == 20000) begin
            n_fail++;
            stop_test();
        end
    end

    task automatic check(input string name, input logic [7:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1;
        ioAddr = a;
        ioWdata = d;
        ioWrite = 1'b1;
        @(posedge mclk);
        #1;
        ioWrite = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        #1;
        ioAddr = a;
        ioRead = 1'b1;
        #2;
        d = ioRdata;
        @(posedge mclk);
        #1;
        ioRead = 1'b0;
    endtask

    task automatic setAddr(input logic [11:0] a);
        wr(AddrHOffset, {4'h0, a[11:8]});
        wr(AddrLOffset, a[7:0]);
    endtask

    task automatic waitIdle(output int n);
        n = 0;
        while (busy !== 1'b0 && n < 200) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n >= 200) begin
            n_fail++;
            stop_test();
        end
    endtask

    task automatic start(input logic [11:0] a, input logic [7:0] d,
                         input logic [1:0] m);
        setAddr(a);
        wr(DataOffset, d);
        wr(CtrlOffset, {2'b00, m, 4'h4});
        wr(CtrlOffset, {2'b00, m, 4'h6});
    endtask

    task automatic prog(input logic [11:0] a, input logic [7:0] d,
                        input logic [1:0] m, output int n);
        start(a, d, m);
        check("busy", {7'h0, busy}, 8'h01);
        waitIdle(n);
    endtask

    task automatic readMem(input logic [11:0] a, output logic [7:0] d);
        setAddr(a);
        wr(CtrlOffset, 8'h01);
        rd(DataOffset, d);
    endtask

    function automatic logic [7:0] pat(input int i);
        return 8'(i * 37 + 5);
    endfunction

    // ****************************************
    // Scenarios.
    // ****************************************
    task automatic testRegisters;
        rd(CtrlOffset, rv);
        check("ctrl reset", rv, 8'h00);
        wr(AddrHOffset, 8'hff);
        rd(AddrHOffset, rv);
        check("addr high", rv, 8'h0f);
        wr(AddrLOffset, 8'h5a);
        rd(AddrLOffset, rv);
        check("addr low", rv, 8'h5a);
        wr(CtrlOffset, 8'hf8);
        rd(CtrlOffset, rv);
        check("ctrl fields", rv, 8'h38);
        rd(8'h30, rv);
        check("unmapped", rv, 8'h00);
        wr(CtrlOffset, 8'h00);
    endtask

    task automatic testSingle;
        int n;
        prog(12'h123, 8'ha5, ModeAtomic, n);
        check("atomic time", {7'h0, n inside {[Wt+Et-2:Wt+Et+2]}}, 8'h01);
        readMem(12'h123, rv);
        check("atomic data", rv, 8'ha5);
        prog(12'h123, 8'h00, ModeErase, n);
        readMem(12'h123, rv);
        check("erase data", rv, ErasedByte);
        prog(12'h123, 8'h3c, ModeWrite, n);
        readMem(12'h123, rv);
        check("write data", rv, 8'h3c);
    endtask

    task automatic testArming;
        wr(CtrlOffset, 8'h02);
        @(posedge mclk);
        #1;
        check("strobe alone", {7'h0, busy}, 8'h00);
        wr(CtrlOffset, 8'h04);
        rd(CtrlOffset, rv);
        check("master set", rv, 8'h04);
        repeat (4) @(posedge mclk);
        rd(CtrlOffset, rv);
        check("master cleared", rv, 8'h00);
        wr(CtrlOffset, 8'h02);
        @(posedge mclk);
        #1;
        check("late strobe", {7'h0, busy}, 8'h00);
    endtask

    task automatic testBusyLocks;
        int n;
        start(12'h200, 8'h11, ModeErase);
        wr(CtrlOffset, 8'h30);
        wr(AddrLOffset, 8'h99);
        rd(CtrlOffset, rv);
        check("mode locked", rv, 8'h12);
        rd(AddrLOffset, rv);
        check("addr locked", rv, 8'h00);
        waitIdle(n);
        rd(CtrlOffset, rv);
        check("strobe done", rv, 8'h10);
    endtask

    task automatic testPage;
        int i;
        int n;
        for (i = 0; i < 7; i++) begin
            prog(12'(12'h040 + i), 8'hff, ModeLoad, n);
        end
        prog(12'h047, 8'hff, ModeErase, n);
        // A junk byte first, so that replacement is visible.
        prog(12'h043, 8'h00, ModeLoad, n);
        for (i = 7; i > 0; i--) begin
            prog(12'(12'h040 + i), pat(i), ModeLoad, n);
        end
        prog(12'h040, pat(0), ModeWrite, n);
        for (i = 0; i < 8; i++) begin
            readMem(12'(12'h040 + i), rv);
            check("page byte", rv, pat(i));
        end
    endtask

    task automatic testIrq;
        int n;
        globalIrqFlag = 1'b1;
        wr(CtrlOffset, 8'h08);
        check("irq on", {7'h0, readyIrq}, 8'h01);
        globalIrqFlag = 1'b0;
        #1;
        check("irq global", {7'h0, readyIrq}, 8'h00);
        globalIrqFlag = 1'b1;
        wr(CtrlOffset, 8'h0c);
        wr(CtrlOffset, 8'h0e);
        @(posedge mclk);
        #1;
        check("irq busy", {7'h0, readyIrq}, 8'h00);
        waitIdle(n);
        check("irq ready", {7'h0, readyIrq}, 8'h01);
        wr(CtrlOffset, 8'h00);
        check("irq off", {7'h0, readyIrq}, 8'h00);
        globalIrqFlag = 1'b0;
    endtask

    task automatic testReset;
        int n;
        start(12'h123, 8'h0f, ModeWrite);
        resetn = 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        check("busy in reset", {7'h0, busy}, 8'h01);
        rd(CtrlOffset, rv);
        check("mode in reset", rv, 8'h22);
        resetn = 1'b1;
        repeat (3) @(posedge mclk);
        waitIdle(n);
        rd(CtrlOffset, rv);
        check("mode kept", rv, 8'h20);
        readMem(12'h123, rv);
        check("write finished", rv, 8'h0c);
    endtask

    // ****************************************
    // Main sequence.
    // ****************************************
    initial begin
        repeat (10) @(posedge mclk);
        #1;
        resetn = 1'b1;
        repeat (3) @(posedge mclk);
        testRegisters();
        testSingle();
        testArming();
        testBusyLocks();
        testPage();
        testIrq();
        testReset();
        stop_test();
    end
endmodule // eeprom_access_controller_bench
`default_nettype wire
